/* File: design/rbd_pkg.sv */
// constants and types for the receive ring and dma pointer block
// Functional notes
// - transmit whole programmed length, never truncate
// - ring first/last pages are 8-bit page numbers
// - compare next buffer page with read boundary
// - abort receive dma when next equals boundary
// - write page restores local pointer on error
// - local dma address readable as byte pair
// - remote dma address readable as byte pair
// - boundary reached sets ring exhausted warning
// - remote transfer end sets done flag
// - overflow status bit follows overflow, read-only
package rbd_pkg;
    localparam logic [7:0] OFS_TX_PAGE    = 8'h00;
    localparam logic [7:0] OFS_TX_LEN_HI  = 8'h04;
    localparam logic [7:0] OFS_TX_LEN_LO  = 8'h08;
    localparam logic [7:0] OFS_RING_START = 8'h0c;
    localparam logic [7:0] OFS_RING_STOP  = 8'h10;
    localparam logic [7:0] OFS_BOUNDARY   = 8'h14;
    localparam logic [7:0] OFS_WRITE_PAGE = 8'h18;
    localparam logic [7:0] OFS_RS_HI      = 8'h1c;
    localparam logic [7:0] OFS_RS_LO      = 8'h20;
    localparam logic [7:0] OFS_RC_HI      = 8'h24;
    localparam logic [7:0] OFS_RC_LO      = 8'h28;
    localparam logic [7:0] OFS_LOC_HI     = 8'h2c;
    localparam logic [7:0] OFS_LOC_LO     = 8'h30;
    localparam logic [7:0] OFS_RMT_HI     = 8'h34;
    localparam logic [7:0] OFS_RMT_LO     = 8'h38;
    localparam logic [7:0] OFS_COMMAND    = 8'h3c;
    localparam logic [7:0] OFS_INT_STATUS = 8'h40;
    localparam logic [7:0] OFS_INT_MASK   = 8'h44;
    localparam int CMD_REMOTE_GO  = 0;
    localparam int CMD_TX_GO      = 1;
    localparam int ST_TX_DONE     = 1;
    localparam int ST_EXHAUSTED   = 4;
    localparam int ST_REMOTE_DONE = 6;
    localparam int ST_OVERFLOW    = 7;
    localparam logic [7:0] STICKY_BITS = 8'h52;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] PAGE_LAST   = 8'hff;
    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } rbd_memwr_t;
endpackage

/* File: design/rbd_ring_dma.sv */
// ring buffer, transmit and remote dma pointer logic with avalon-mm registers
`timescale 1ns/10ps
`default_nettype none
module rbd_ring_dma (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [7:0]        avsAddress,
    input  wire logic              avsRead,
    input  wire logic              avsWrite,
    input  wire logic [3:0]        avsByteenable,
    input  wire logic [31:0]       avsWritedata,
    output logic [31:0]            avsReaddata,
    output logic                   avsWaitrequest,
    output logic                   irq,
    input  wire logic              rxValid,
    input  wire logic [7:0]        rxData,
    input  wire logic              rxEnd,
    input  wire logic              rxErr,
    output rbd_pkg::rbd_memwr_t    memWr,
    output logic                   txBusy,
    output logic [15:0]            txAddr,
    input  wire logic              txAck,
    output logic                   rmtBusy,
    output logic [15:0]            rmtAddr,
    input  wire logic              rmtAck
);
    logic [7:0]  txPage_reg, txLenHi_reg, txLenLo_reg, start_reg, stop_reg, ring_read_boundary_reg;
    logic [7:0]  wrPage_reg, rsHi_reg, rsLo_reg, rcHi_reg, rcLo_reg;
    logic [7:0]  status_reg, mask_reg;
    logic [15:0] loc_reg, txLeft_reg, rmtCnt_reg;
    logic        abort_reg, ovf_reg;
    logic        wait_reg;
    logic [31:0] rd_reg;

    // next page after a given one, wrapping from stop back to start
    function automatic logic [7:0] pageAfter(input logic [7:0] p, input logic [7:0] s,
                                             input logic [7:0] e);
        logic [7:0] n;
        n = p + 8'h01;
        pageAfter = (n == e) ? s : n;
    endfunction

    // bus decode; a write lands only on the edge where waitrequest is low
    wire         wrTake = avsWrite && !wait_reg && avsByteenable[0];
    wire [7:0]   wd     = avsWritedata[7:0];
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o, input logic t);
        hit = t && (a == o);
    endfunction
    wire wTxPage = hit(avsAddress, rbd_pkg::OFS_TX_PAGE, wrTake);
    wire wTxHi   = hit(avsAddress, rbd_pkg::OFS_TX_LEN_HI, wrTake);
    wire wTxLo   = hit(avsAddress, rbd_pkg::OFS_TX_LEN_LO, wrTake);
    wire wStart  = hit(avsAddress, rbd_pkg::OFS_RING_START, wrTake);
    wire wStop   = hit(avsAddress, rbd_pkg::OFS_RING_STOP, wrTake);
    wire wBnry   = hit(avsAddress, rbd_pkg::OFS_BOUNDARY, wrTake);
    wire wWrPage = hit(avsAddress, rbd_pkg::OFS_WRITE_PAGE, wrTake);
    wire wRsHi   = hit(avsAddress, rbd_pkg::OFS_RS_HI, wrTake);
    wire wRsLo   = hit(avsAddress, rbd_pkg::OFS_RS_LO, wrTake);
    wire wRcHi   = hit(avsAddress, rbd_pkg::OFS_RC_HI, wrTake);
    wire wRcLo   = hit(avsAddress, rbd_pkg::OFS_RC_LO, wrTake);
    wire wCmd    = hit(avsAddress, rbd_pkg::OFS_COMMAND, wrTake);
    wire wStat   = hit(avsAddress, rbd_pkg::OFS_INT_STATUS, wrTake);
    wire wMask   = hit(avsAddress, rbd_pkg::OFS_INT_MASK, wrTake);
    wire goRmt   = wCmd && wd[rbd_pkg::CMD_REMOTE_GO];
    wire goTx    = wCmd && wd[rbd_pkg::CMD_TX_GO];

    // receive side
    wire [7:0]  curPage  = loc_reg[15:8];
    wire        pageEnd  = (loc_reg[7:0] == rbd_pkg::PAGE_LAST);
    wire [7:0]  nextPage = pageAfter(curPage, start_reg, stop_reg);
    wire        hitBnry  = (nextPage == ring_read_boundary_reg);
    wire        store    = rxValid && !abort_reg;
    wire        exhaust  = store && pageEnd && hitBnry;
    wire [15:0] pktDone  = {pageAfter(curPage, start_reg, stop_reg), rbd_pkg::RESET_BYTE};
    wire [15:0] restore  = {wrPage_reg, rbd_pkg::RESET_BYTE};
    logic [15:0] loc_next;
    always_comb begin
        loc_next = loc_reg;
        if (wWrPage)
            loc_next = {wd, rbd_pkg::RESET_BYTE};
        else if (rxEnd)
            loc_next = (rxErr || abort_reg) ? restore : pktDone;
        else if (store && !exhaust)
            loc_next = pageEnd ? {nextPage, rbd_pkg::RESET_BYTE} : loc_reg + 16'h0001;
    end
    wire        goodEnd = rxEnd && !rxErr && !abort_reg && !wWrPage;

    // remote and transmit counters
    wire rmtStep  = rmtBusy && rmtAck;
    wire rmtFin   = rmtStep && (rmtCnt_reg == 16'h0001);
    wire rmtZero  = goRmt && ({rcHi_reg, rcLo_reg} == 16'h0000);
    wire txStep   = txBusy && txAck;
    wire txFin    = txStep && (txLeft_reg == 16'h0001);

    // status: set wins over write-one-to-clear
    logic [7:0] setBits;
    always_comb begin
        setBits = 8'h00;
        setBits[rbd_pkg::ST_TX_DONE]     = txFin;
        setBits[rbd_pkg::ST_EXHAUSTED]   = exhaust;
        setBits[rbd_pkg::ST_REMOTE_DONE] = rmtFin || rmtZero;
    end
    wire [7:0] clrBits     = wStat ? (wd & rbd_pkg::STICKY_BITS) : 8'h00;
    wire [7:0] status_next = ((status_reg & ~clrBits) | setBits) & rbd_pkg::STICKY_BITS;
    wire [7:0] statusView  = status_reg | ({7'h00, ovf_reg} << rbd_pkg::ST_OVERFLOW);

    logic [7:0] rdByte;
    always_comb begin
        unique case (avsAddress)
            rbd_pkg::OFS_TX_PAGE:    rdByte = txPage_reg;
            rbd_pkg::OFS_TX_LEN_HI:  rdByte = txLenHi_reg;
            rbd_pkg::OFS_TX_LEN_LO:  rdByte = txLenLo_reg;
            rbd_pkg::OFS_RING_START: rdByte = start_reg;
            rbd_pkg::OFS_RING_STOP:  rdByte = stop_reg;
            rbd_pkg::OFS_BOUNDARY:   rdByte = ring_read_boundary_reg;
            rbd_pkg::OFS_WRITE_PAGE: rdByte = wrPage_reg;
            rbd_pkg::OFS_RS_HI:      rdByte = rsHi_reg;
            rbd_pkg::OFS_RS_LO:      rdByte = rsLo_reg;
            rbd_pkg::OFS_RC_HI:      rdByte = rcHi_reg;
            rbd_pkg::OFS_RC_LO:      rdByte = rcLo_reg;
            rbd_pkg::OFS_LOC_HI:     rdByte = loc_reg[15:8];
            rbd_pkg::OFS_LOC_LO:     rdByte = loc_reg[7:0];
            rbd_pkg::OFS_RMT_HI:     rdByte = rmtAddr[15:8];
            rbd_pkg::OFS_RMT_LO:     rdByte = rmtAddr[7:0];
            rbd_pkg::OFS_COMMAND:    rdByte = {6'h00, txBusy, rmtBusy};
            rbd_pkg::OFS_INT_STATUS: rdByte = statusView;
            rbd_pkg::OFS_INT_MASK:   rdByte = mask_reg;
            default:                 rdByte = 8'h00;
        endcase
    end

    // one wait cycle per access keeps read data registered
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wait_reg <= 1'b1;
            rd_reg   <= 32'h0000_0000;
        end else begin
            wait_reg <= !((avsRead || avsWrite) && wait_reg);
            if (avsRead && wait_reg)
                rd_reg <= {24'h00_0000, rdByte};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txPage_reg  <= rbd_pkg::RESET_BYTE;
            txLenHi_reg <= rbd_pkg::RESET_BYTE;
            txLenLo_reg <= rbd_pkg::RESET_BYTE;
            start_reg   <= rbd_pkg::RESET_BYTE;
            stop_reg    <= rbd_pkg::RESET_BYTE;
            ring_read_boundary_reg    <= rbd_pkg::RESET_BYTE;
            rsHi_reg    <= rbd_pkg::RESET_BYTE;
            rsLo_reg    <= rbd_pkg::RESET_BYTE;
            rcHi_reg    <= rbd_pkg::RESET_BYTE;
            rcLo_reg    <= rbd_pkg::RESET_BYTE;
            mask_reg    <= rbd_pkg::RESET_BYTE;
        end else begin
            if (wTxPage) txPage_reg  <= wd;
            if (wTxHi)   txLenHi_reg <= wd;
            if (wTxLo)   txLenLo_reg <= wd;
            if (wStart)  start_reg   <= wd;
            if (wStop)   stop_reg    <= wd;
            if (wBnry)   ring_read_boundary_reg    <= wd;
            if (wRsHi)   rsHi_reg    <= wd;
            if (wRsLo)   rsLo_reg    <= wd;
            if (wRcHi)   rcHi_reg    <= wd;
            if (wRcLo)   rcLo_reg    <= wd;
            if (wMask)   mask_reg    <= wd;
        end
    end

    // receive ring state; overflow holds until software writes the boundary register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loc_reg    <= 16'h0000;
            wrPage_reg <= rbd_pkg::RESET_BYTE;
            abort_reg  <= 1'b0;
            ovf_reg    <= 1'b0;
            memWr      <= '0;
        end else begin
            loc_reg <= loc_next;
            if (wWrPage)
                wrPage_reg <= wd;
            else if (goodEnd)
                wrPage_reg <= pktDone[15:8];
            abort_reg <= rxEnd ? 1'b0 : (abort_reg || exhaust);
            ovf_reg   <= exhaust || (ovf_reg && !wBnry);
            memWr.en   <= store;
            memWr.addr <= loc_reg;
            memWr.data <= rxData;
        end
    end

    // remote and transmit engines, status and interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rmtBusy    <= 1'b0;
            rmtAddr    <= 16'h0000;
            rmtCnt_reg <= 16'h0000;
            txBusy     <= 1'b0;
            txAddr     <= 16'h0000;
            txLeft_reg <= 16'h0000;
            status_reg <= rbd_pkg::RESET_BYTE;
            irq        <= 1'b0;
        end else begin
            if (goRmt) begin
                rmtAddr    <= {rsHi_reg, rsLo_reg};
                rmtCnt_reg <= {rcHi_reg, rcLo_reg};
                rmtBusy    <= !rmtZero;
            end else if (rmtStep) begin
                rmtAddr    <= rmtAddr + 16'h0001;
                rmtCnt_reg <= rmtCnt_reg - 16'h0001;
                rmtBusy    <= !rmtFin;
            end
            if (goTx) begin
                txAddr     <= {txPage_reg, rbd_pkg::RESET_BYTE};
                txLeft_reg <= {txLenHi_reg, txLenLo_reg};
                txBusy     <= ({txLenHi_reg, txLenLo_reg} != 16'h0000);
            end else if (txStep) begin
                txAddr     <= txAddr + 16'h0001;
                txLeft_reg <= txLeft_reg - 16'h0001;
                txBusy     <= !txFin;
            end
            status_reg <= status_next;
            irq        <= |(status_next & mask_reg);
        end
    end

    assign avsWaitrequest = wait_reg;
    assign avsReaddata    = rd_reg;

    // checks
    sequence rmtLast_s;
        rmtBusy && rmtAck && rmtCnt_reg == 16'h0001;
    endsequence
    sequence rmtDoneSeen_s;
        !rmtBusy && status_reg[rbd_pkg::ST_REMOTE_DONE];
    endsequence
    property rmtEnd_p;
        @(posedge clk) disable iff (!rst_b) rmtLast_s |=> rmtDoneSeen_s;
    endproperty
    remote_done_a: assert property (rmtEnd_p)
        else $error("remote done flag missing after last byte");
    remote_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        rmtBusy && rmtAck && !goRmt |=> rmtAddr == $past(rmtAddr) + 16'h0001
            && rmtCnt_reg == $past(rmtCnt_reg) - 16'h0001)
        else $error("remote address or count did not step");
    tx_full_a: assert property (@(posedge clk) disable iff (!rst_b)
        txBusy && txAck && txLeft_reg > 16'h0001 && !goTx |=> txBusy)
        else $error("transmit ended before programmed length");
    ring_read_boundary_abort_a: assert property (@(posedge clk) disable iff (!rst_b)
        exhaust && !rxEnd && !wWrPage |=> abort_reg && loc_reg == $past(loc_reg))
        else $error("receive not aborted at boundary");
    exhaust_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        exhaust |=> status_reg[rbd_pkg::ST_EXHAUSTED] && ovf_reg)
        else $error("exhausted warning not set");
    ring_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        store && pageEnd && !exhaust && !rxEnd && !wWrPage
            && curPage + 8'h01 == stop_reg |=> loc_reg == {start_reg, 8'h00})
        else $error("write pointer did not wrap to ring start");
    err_restore_a: assert property (@(posedge clk) disable iff (!rst_b)
        rxEnd && rxErr && !wWrPage |=> loc_reg == {$past(wrPage_reg), 8'h00})
        else $error("local pointer not restored after receive error");
    ovf_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        ovf_reg && !wBnry && !exhaust |=> ovf_reg ##1 ovf_reg || $past(wBnry))
        else $error("overflow status dropped while boundary unchanged");
    loc_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        avsRead && wait_reg && avsAddress == rbd_pkg::OFS_LOC_LO
            |=> !avsWaitrequest && avsReaddata[7:0] == $past(loc_reg[7:0]))
        else $error("local pointer readback wrong");
    rmt_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        avsRead && wait_reg && avsAddress == rbd_pkg::OFS_RMT_HI
            |=> avsReaddata[7:0] == $past(rmtAddr[15:8]))
        else $error("remote pointer readback wrong");
    sequence busTake_s;
        (avsRead || avsWrite) && wait_reg;
    endsequence
    sequence busAnswer_s;
        !avsWaitrequest ##1 avsWaitrequest;
    endsequence
    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
        busTake_s |=> busAnswer_s)
        else $error("waitrequest not low for exactly one cycle");
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        $stable(mask_reg) |-> irq == |(status_reg & mask_reg))
        else $error("interrupt level does not follow masked status");
    rmt_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        rmtZero |=> !rmtBusy && status_reg[rbd_pkg::ST_REMOTE_DONE])
        else $error("zero count remote transfer not done at once");
    tx_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        txFin && !goTx |=> !txBusy && status_reg[rbd_pkg::ST_TX_DONE])
        else $error("transmit done flag missing after last byte");
    store_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
        store |=> memWr.en && memWr.addr == $past(loc_reg))
        else $error("stored byte not at local pointer");
    ovf_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        wStat && !exhaust |=> ovf_reg == $past(ovf_reg))
        else $error("status write changed overflow bit");
    abort_restore_a: assert property (@(posedge clk) disable iff (!rst_b)
        rxEnd && abort_reg && !wWrPage |=> loc_reg == {$past(wrPage_reg), 8'h00} && !abort_reg)
        else $error("aborted packet end did not restore pointer");
    page_advance_a: assert property (@(posedge clk) disable iff (!rst_b)
        goodEnd |=> loc_reg[7:0] == 8'h00 && wrPage_reg == loc_reg[15:8])
        else $error("write page not moved after good packet");
endmodule // rbd_ring_dma
`default_nettype wire

/* File: verification/rbd_far_side.sv */
// partner model: transmit and remote byte consumers facing the dma engine
`timescale 1ns/10ps
`default_nettype none
module rbd_far_side (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        txBusy,
    input  wire logic        rmtBusy,
    input  wire logic        slow,
    output logic             txAck,
    output logic             rmtAck,
    output logic [15:0]      txCount
);
    logic phase;
    // acks only answer a running transfer; slow mode halves the byte rate
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase <= 1'b0;
            txAck <= 1'b0;
            rmtAck <= 1'b0;
            txCount <= 16'h0000;
        end else begin
            phase <= ~phase;
            txAck <= txBusy & (~slow | phase);
            rmtAck <= rmtBusy & (~slow | phase);
            // an ack that lands after busy fell is not a consumed byte
            if (txAck && txBusy) begin
                txCount <= txCount + 16'h0001;
            end
        end
    end
endmodule // rbd_far_side
`default_nettype wire

/* File: verification/tb_rbd_ring_dma.sv */
// self-checking bench for the ring, transmit and remote dma pointer block
`timescale 1ns/10ps
`default_nettype none
module tb_rbd_ring_dma;
    logic clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, irq, avsWaitrequest;
    logic [7:0] avsAddress = 8'h00, rxData = 8'h00;
    logic [3:0] avsByteenable = 4'h1;
    logic [31:0] avsWritedata = 32'h0, avsReaddata;
    logic rxValid = 1'b0, rxEnd = 1'b0, rxErr = 1'b0, slow = 1'b0;
    logic txBusy, txAck, rmtBusy, rmtAck;
    logic [15:0] txAddr, rmtAddr, txCount;
    rbd_pkg::rbd_memwr_t memWr;
    int failures = 0, cmp_count = 0;
    rbd_ring_dma u_rbd_ring_dma (.clk(clk), .rst_b(rst_b), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsByteenable(avsByteenable),
        .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .irq(irq), .rxValid(rxValid), .rxData(rxData),
        .rxEnd(rxEnd), .rxErr(rxErr), .memWr(memWr), .txBusy(txBusy), .txAddr(txAddr),
        .txAck(txAck), .rmtBusy(rmtBusy), .rmtAddr(rmtAddr), .rmtAck(rmtAck));
    rbd_far_side u_rbd_far_side (.clk(clk), .rst_b(rst_b), .txBusy(txBusy),
        .rmtBusy(rmtBusy), .slow(slow), .txAck(txAck), .rmtAck(rmtAck), .txCount(txCount));
    initial begin
        forever #25 clk = ~clk;
    end
    task wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // holds the request until waitrequest is sampled low, then releases
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= ~w;
        avsWritedata <= {24'h000000, d};
        @(posedge clk);
        while (avsWaitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                failures++;
                $display("Error at %0t: bus request not answered", $time);
                wrap_up();
            end
            @(posedge clk);
        end
        q = avsReaddata[7:0];
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, e}, "register read");
    endtask
    task automatic waitb(input logic tx, input logic lvl);
        int n;
        n = 0;
        while ((tx ? txBusy : rmtBusy) !== lvl) begin
            n++;
            if (n > 5000) begin
                failures++;
                $display("Error at %0t: busy level not reached", $time);
                wrap_up();
            end
            @(posedge clk);
        end
    endtask
    task automatic send(input int n, input logic [7:0] d);
        for (int i = 0; i < n; i++) begin
            rxValid <= 1'b1;
            rxData <= d + i[7:0];
            @(posedge clk);
        end
        rxValid <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(rbd_pkg::OFS_TX_PAGE, 8'h00);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h00);
        rd(rbd_pkg::OFS_LOC_LO, 8'h00);
        rd(8'h48, 8'h00);
        avsByteenable <= 4'h0;
        wr(rbd_pkg::OFS_TX_PAGE, 8'h77);
        avsByteenable <= 4'h1;
        rd(rbd_pkg::OFS_TX_PAGE, 8'h00);
        $display("test reset done");
        wr(rbd_pkg::OFS_RING_START, 8'h10);
        wr(rbd_pkg::OFS_RING_STOP, 8'h11);
        wr(rbd_pkg::OFS_BOUNDARY, 8'h20);
        wr(rbd_pkg::OFS_WRITE_PAGE, 8'h10);
        rd(rbd_pkg::OFS_RING_STOP, 8'h11);
        send(1, 8'h5a);
        #1;
        chk({15'h0000, memWr.en}, 16'h0001, "store strobe");
        chk(memWr.addr, 16'h1000, "store address");
        chk({8'h00, memWr.data}, 16'h005a, "store data");
        @(posedge clk);
        send(255, 8'h00);
        rd(rbd_pkg::OFS_LOC_HI, 8'h10);
        rd(rbd_pkg::OFS_LOC_LO, 8'h00);
        // second lap: the wrapped next page equals the boundary
        wr(rbd_pkg::OFS_BOUNDARY, 8'h10);
        send(256, 8'h00);
        wr(rbd_pkg::OFS_INT_MASK, 8'h10);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h90);
        chk({15'h0000, irq}, 16'h0001, "irq on exhausted");
        rxEnd <= 1'b1;
        rxErr <= 1'b1;
        @(posedge clk);
        rxEnd <= 1'b0;
        rxErr <= 1'b0;
        rd(rbd_pkg::OFS_LOC_HI, 8'h10);
        rd(rbd_pkg::OFS_LOC_LO, 8'h00);
        wr(rbd_pkg::OFS_INT_STATUS, 8'h90);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h80);
        chk({15'h0000, irq}, 16'h0000, "irq after clear");
        wr(rbd_pkg::OFS_BOUNDARY, 8'h20);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h00);
        wr(rbd_pkg::OFS_RING_STOP, 8'h12);
        send(2, 8'h33);
        rxEnd <= 1'b1;
        @(posedge clk);
        rxEnd <= 1'b0;
        rd(rbd_pkg::OFS_LOC_HI, 8'h11);
        rd(rbd_pkg::OFS_WRITE_PAGE, 8'h11);
        $display("test receive ring done");
        slow <= 1'b1;
        wr(rbd_pkg::OFS_RS_HI, 8'h12);
        wr(rbd_pkg::OFS_RS_LO, 8'hfe);
        wr(rbd_pkg::OFS_RC_HI, 8'h00);
        wr(rbd_pkg::OFS_RC_LO, 8'h03);
        wr(rbd_pkg::OFS_COMMAND, 8'h01);
        waitb(1'b0, 1'b1);
        chk(rmtAddr, 16'h12fe, "remote start");
        rd(rbd_pkg::OFS_COMMAND, 8'h01);
        waitb(1'b0, 1'b0);
        rd(rbd_pkg::OFS_RMT_HI, 8'h13);
        rd(rbd_pkg::OFS_RMT_LO, 8'h01);
        wr(rbd_pkg::OFS_INT_MASK, 8'h40);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h40);
        chk({15'h0000, irq}, 16'h0001, "irq on remote done");
        wr(rbd_pkg::OFS_INT_STATUS, 8'h40);
        wr(rbd_pkg::OFS_RC_LO, 8'h00);
        wr(rbd_pkg::OFS_COMMAND, 8'h01);
        rd(rbd_pkg::OFS_INT_STATUS, 8'h40);
        wr(rbd_pkg::OFS_INT_STATUS, 8'h40);
        $display("test remote dma done");
        slow <= 1'b0;
        wr(rbd_pkg::OFS_TX_PAGE, 8'h40);
        wr(rbd_pkg::OFS_TX_LEN_HI, 8'h05);
        wr(rbd_pkg::OFS_TX_LEN_LO, 8'hdd);
        rd(rbd_pkg::OFS_TX_LEN_LO, 8'hdd);
        wr(rbd_pkg::OFS_COMMAND, 8'h02);
        waitb(1'b1, 1'b1);
        chk(txAddr, 16'h4000, "transmit start");
        rd(rbd_pkg::OFS_COMMAND, 8'h02);
        waitb(1'b1, 1'b0);
        chk(txCount, 16'h05dd, "bytes sent");
        chk(txAddr, 16'h45dd, "transmit end address");
        rd(rbd_pkg::OFS_INT_STATUS, 8'h02);
        $display("test transmit done");
        wrap_up();
    end
endmodule // tb_rbd_ring_dma
`default_nettype wire
